// ### core/rbc_engine.v
// Receive frame and buffer descriptor memory engine
`default_nettype none
`include "rbc_regs.vh"
module rbc_engine (
    input  wire        ref_clk,
    input  wire        rstn,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // Receive byte stream
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    input  wire [4:0]  rx_err,
    output wire        rx_ready,
    // System memory master
    output reg         mem_req,
    output reg         mem_we,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    output reg  [3:0]  mem_be,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    // Receive unit state
    output wire        ru_ready,
    output wire        ru_no_resources
);
    // ---------------------------------------------------------------
    // Reset and registers
    // ---------------------------------------------------------------
    wire        rst_n;
    wire        ctl_start;
    wire        ctl_save_bad;
    wire [1:0]  ctl_mode;
    wire [31:0] fd_head;
    reg  [31:0] nores_cnt;
    reg  [31:0] fd_addr;
    reg  [31:0] bd_addr;

    rbc_sync u_sync (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .rst_sync_n (rst_n)
    );

    localparam [13:0] S_IDLE  = 14'h0001;
    localparam [13:0] S_FDST  = 14'h0002;
    localparam [13:0] S_FDSZ  = 14'h0004;
    localparam [13:0] S_FDPTR = 14'h0008;
    localparam [13:0] S_BUSY  = 14'h0010;
    localparam [13:0] S_BDRD  = 14'h0020;
    localparam [13:0] S_RECV  = 14'h0040;
    localparam [13:0] S_WORD  = 14'h0080;
    localparam [13:0] S_BDWR  = 14'h0100;
    localparam [13:0] S_FDCNT = 14'h0200;
    localparam [13:0] S_FDFIN = 14'h0400;
    localparam [13:0] S_NXPTR = 14'h0800;
    localparam [13:0] S_NORES = 14'h1000;
    localparam [13:0] S_BDSZ  = 14'h2000;

    reg  [13:0] state;

    rbc_regfile u_regs (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .ctl_start    (ctl_start),
        .ctl_save_bad (ctl_save_bad),
        .ctl_mode     (ctl_mode),
        .fd_head      (fd_head),
        .stat_state   ({18'h0, state}),
        .stat_nores   (nores_cnt),
        .stat_fd      (fd_addr),
        .stat_bd      (bd_addr)
    );

    // ---------------------------------------------------------------
    // Working state
    // ---------------------------------------------------------------
    reg  [31:0] fd_word0;     // Status/command word of frame descriptor
    reg  [13:0] fd_size;      // Data area size in frame descriptor
    reg  [13:0] fd_cnt;       // Bytes placed in frame descriptor
    reg  [31:0] buf_addr;     // Current buffer base
    reg  [13:0] buf_size;
    reg  [13:0] buf_cnt;
    reg  [31:0] bd_next;      // Prefetched next buffer descriptor
    reg         have_bd;      // Buffer descriptor fetch has begun
    reg         nx_valid;     // Prefetched pointer is valid
    reg         in_buf;       // Data now goes to a buffer
    reg         trunc;
    reg         chained;
    reg  [31:0] first_bd;
    reg  [31:0] word;
    reg  [1:0]  lane;
    reg  [31:0] word_addr;
    reg  [4:0]  err;
    reg         last_seen;

    wire flex      = fd_word0[`RBC_BIT_SF];
    wire mode_ok   = (ctl_mode == `RBC_MODE_SEG) ||
                     (ctl_mode == `RBC_MODE_LINEAR);
    wire fd_full   = (fd_cnt == fd_size);
    wire buf_full  = (buf_cnt == buf_size);
    wire bad_frame = trunc || (err != 5'h00);
    wire keep      = !bad_frame || ctl_save_bad;
    // Lanes filled so far
    wire [3:0] fill_be = (lane == 2'h0) ? 4'hF : ~(4'hF << lane);
    wire [31:0] sum_addr = in_buf ? buf_addr + {18'h0, buf_cnt}
                                  : fd_addr + `RBC_FD_DATA + {18'h0, fd_cnt};

    assign rx_ready        = (state == S_RECV);
    assign ru_ready        = (state != S_IDLE) && (state != S_NORES);
    assign ru_no_resources = (state == S_NORES);

    // Memory access launcher
    task mem_go;
        input        we;
        input [31:0] a;
        input [31:0] d;
        input [3:0]  be;
        begin
            mem_req   <= 1'b1;
            mem_we    <= we;
            mem_addr  <= a;
            mem_wdata <= d;
            mem_be    <= be;
        end
    endtask

    // ---------------------------------------------------------------
    // Main sequencer
    // ---------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_wdata <= 32'h00000000;
            mem_be <= 4'h0;
            nores_cnt <= 32'h00000000;
            fd_addr <= 32'h00000000;
            bd_addr <= `RBC_NULL_PTR;
            fd_word0 <= 32'h00000000;
            fd_size <= 14'h0000;
            fd_cnt <= 14'h0000;
            buf_addr <= 32'h00000000;
            buf_size <= 14'h0000;
            buf_cnt <= 14'h0000;
            bd_next <= `RBC_NULL_PTR;
            have_bd <= 1'b0;
            nx_valid <= 1'b0;
            in_buf <= 1'b0;
            trunc <= 1'b0;
            chained <= 1'b0;
            first_bd <= `RBC_NULL_PTR;
            word <= 32'h00000000;
            lane <= 2'h0;
            word_addr <= 32'h00000000;
            err <= 5'h00;
            last_seen <= 1'b0;
        end else begin
            if (mem_ack)
                mem_req <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (ctl_start && mode_ok) begin
                        fd_addr <= fd_head;
                        state <= S_FDST;
                        mem_go(1'b0, fd_head + `RBC_FD_STATUS, 32'h0, 4'hF);
                    end
                end
                S_FDST: if (mem_ack) begin
                    fd_word0 <= mem_rdata;
                    state <= S_FDSZ;
                    mem_go(1'b0, fd_addr + `RBC_FD_COUNT, 32'h0, 4'hF);
                end
                S_FDSZ: if (mem_ack) begin
                    fd_size <= mem_rdata[29:16];
                    state <= S_FDPTR;
                    mem_go(1'b0, fd_addr + `RBC_FD_BDPTR, 32'h0, 4'hF);
                end
                S_FDPTR: if (mem_ack) begin
                    // Kept chain head overrides the host's all-ones field
                    if (mem_rdata != `RBC_NULL_PTR)
                        bd_addr <= mem_rdata;
                    have_bd <= 1'b0;
                    nx_valid <= 1'b0;
                    in_buf <= 1'b0;
                    fd_cnt <= 14'h0000;
                    trunc <= 1'b0;
                    chained <= 1'b0;
                    err <= 5'h00;
                    last_seen <= 1'b0;
                    lane <= 2'h0;
                    word <= 32'h00000000;
                    state <= S_BUSY;
                    mem_go(1'b1, fd_addr + `RBC_FD_STATUS,
                           32'h00004000, 4'h3);
                end
                S_BUSY: if (mem_ack) begin
                    first_bd <= bd_addr;
                    state <= S_RECV;
                end
                S_RECV: if (rx_valid) begin
                    if (rx_last) begin
                        err <= rx_err;
                        last_seen <= 1'b1;
                    end
                    if (!in_buf && fd_full && !flex) begin
                        trunc <= 1'b1;
                    end else if (!in_buf && fd_full) begin
                        trunc <= 1'b1;
                    end else begin
                        word <= word | ({24'h0, rx_data} << {lane, 3'b000});
                        word_addr <= {sum_addr[31:2], 2'b00};
                        if (in_buf)
                            buf_cnt <= buf_cnt + 14'h0001;
                        else
                            fd_cnt <= fd_cnt + 14'h0001;
                        lane <= lane + 2'h1;
                        state <= S_WORD;
                    end
                    if (rx_last && !(!in_buf && !fd_full) &&
                        !(in_buf || !fd_full))
                        state <= S_FDCNT;
                end
                S_WORD: begin
                    // Flush word on lane wrap, buffer or data area fill, or frame end
                    if (!mem_req && (lane == 2'h0 || last_seen ||
                        (in_buf && buf_full) || (!in_buf && fd_full))) begin
                        mem_go(1'b1, word_addr, word, fill_be);
                        state <= S_BDSZ;
                    end else if (!mem_req) begin
                        state <= last_seen ? S_FDCNT : S_RECV;
                    end
                end
                S_BDSZ: if (mem_ack) begin
                    word <= 32'h00000000;
                    lane <= 2'h0;
                    if (last_seen)
                        state <= in_buf ? S_BDWR : S_FDCNT;
                    else if (in_buf && buf_full)
                        state <= S_BDWR;
                    else if (!in_buf && fd_full && flex)
                        state <= S_BDRD;
                    else
                        state <= S_RECV;
                end
                S_BDRD: begin
                    // Load descriptor at bd_addr: size, buffer, next
                    if (bd_addr == `RBC_NULL_PTR) begin
                        nores_cnt <= nores_cnt + 32'h1;
                        state <= S_NORES;
                    end else if (!mem_req && !have_bd) begin
                        mem_go(1'b0, bd_addr + `RBC_BD_SIZE, 32'h0, 4'hF);
                        have_bd <= 1'b1;
                    end else if (mem_ack && mem_addr[3:0] == `RBC_BD_SIZE) begin
                        buf_size <= mem_rdata[13:0];
                        mem_go(1'b0, bd_addr + `RBC_BD_BUF, 32'h0, 4'hF);
                    end else if (mem_ack && mem_addr[3:0] == `RBC_BD_BUF) begin
                        buf_addr <= {mem_rdata[31:1], 1'b0};
                        // Prefetch next descriptor pointer now
                        mem_go(1'b0, bd_addr + `RBC_BD_NEXT, 32'h0, 4'hF);
                    end else if (mem_ack) begin
                        bd_next <= mem_rdata;
                        nx_valid <= 1'b1;
                        buf_cnt <= 14'h0000;
                        in_buf <= 1'b1;
                        chained <= 1'b1;
                        state <= S_RECV;
                    end
                end
                S_BDWR: if (!mem_req) begin
                    // Count and end-of-frame into finished buffer
                    mem_go(1'b1, bd_addr + `RBC_BD_COUNT,
                           {16'h0, last_seen, 1'b1, buf_cnt}, 4'h3);
                    state <= S_NXPTR;
                end
                S_NXPTR: if (mem_ack) begin
                    bd_addr <= nx_valid ? bd_next : `RBC_NULL_PTR;
                    have_bd <= 1'b0;
                    nx_valid <= 1'b0;
                    state <= last_seen ? S_FDCNT : S_BDRD;
                end
                S_FDCNT: if (!mem_req) begin
                    if (trunc)
                        nores_cnt <= nores_cnt + 32'h1;
                    mem_go(1'b1, fd_addr + `RBC_FD_COUNT,
                           {16'h0, 1'b1, 1'b1, fd_cnt}, 4'h3);
                    state <= S_FDFIN;
                end
                S_FDFIN: if (mem_ack) begin
                    // Count, status, link, pointer
                    if (mem_addr == fd_addr + `RBC_FD_COUNT && !keep) begin
                        // Reuse same descriptor and its buffers
                        bd_addr <= first_bd;
                        state <= S_FDST;
                        mem_go(1'b0, fd_addr + `RBC_FD_STATUS, 32'h0, 4'hF);
                    end else if (mem_addr == fd_addr + `RBC_FD_COUNT) begin
                        mem_go(1'b1, fd_addr + `RBC_FD_STATUS,
                               {16'h0, 2'b10, !bad_frame,
                                err | {3'b000, trunc, 1'b0},
                                8'h00}, 4'h3);
                    end else if (mem_addr == fd_addr) begin
                        if (fd_word0[`RBC_BIT_EL])
                            state <= S_IDLE;
                        else
                            mem_go(1'b0, fd_addr + `RBC_FD_LINK, 32'h0, 4'hF);
                    end else if (!mem_we) begin
                        fd_addr <= mem_rdata;
                        mem_go(1'b1, mem_rdata + `RBC_FD_BDPTR,
                               bd_addr, 4'hF);
                    end else begin
                        // Fetch the next descriptor
                        state <= S_FDST;
                        mem_go(1'b0, fd_addr + `RBC_FD_STATUS, 32'h0, 4'hF);
                    end
                end
                S_NORES: begin
                    if (ctl_start && mode_ok) begin
                        fd_addr <= fd_head;
                        state <= S_FDST;
                        mem_go(1'b0, fd_head + `RBC_FD_STATUS, 32'h0, 4'hF);
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### core/rbc_regfile.v
// Software register port of the receive buffer chaining engine
`default_nettype none
`include "rbc_regs.vh"
module rbc_regfile (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    output reg         ctl_start,
    output reg         ctl_save_bad,
    output reg  [1:0]  ctl_mode,
    output reg  [31:0] fd_head,
    input  wire [31:0] stat_state,
    input  wire [31:0] stat_nores,
    input  wire [31:0] stat_fd,
    input  wire [31:0] stat_bd
);
    // Writes; start is a one-cycle pulse
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_start    <= 1'b0;
            ctl_save_bad <= 1'b0;
            ctl_mode     <= 2'h0;
            fd_head      <= 32'h00000000;
        end else begin
            ctl_start <= 1'b0;
            if (reg_wr && reg_addr == `RBC_REG_CTRL) begin
                ctl_start    <= reg_wdata[`RBC_CTRL_START];
                ctl_save_bad <= reg_wdata[`RBC_CTRL_SAVEBAD];
                ctl_mode     <= reg_wdata[`RBC_CTRL_MODE_LO+1:`RBC_CTRL_MODE_LO];
            end
            if (reg_wr && reg_addr == `RBC_REG_FDHEAD)
                fd_head <= reg_wdata;
        end
    end
    // Reads answer one cycle later; unmapped reads give zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `RBC_REG_CTRL:   reg_rdata <= {28'h0, ctl_mode,
                                               ctl_save_bad, 1'b0};
                `RBC_REG_FDHEAD: reg_rdata <= fd_head;
                `RBC_REG_STATE:  reg_rdata <= stat_state;
                `RBC_REG_NORES:  reg_rdata <= stat_nores;
                `RBC_REG_FDCUR:  reg_rdata <= stat_fd;
                `RBC_REG_BDCUR:  reg_rdata <= stat_bd;
                default:         reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ### core/rbc_regs.vh
// Constants for the receive buffer chaining engine
`ifndef RBC_REGS_VH
`define RBC_REGS_VH
// ---------------------------------------------------------------
// Frame and buffer descriptor layout, linear mode byte offsets
// ---------------------------------------------------------------
`define RBC_FD_STATUS      8'h00
`define RBC_FD_LINK        8'h04
`define RBC_FD_BDPTR       8'h08
`define RBC_FD_COUNT       8'h0C
`define RBC_FD_DATA        8'h20
`define RBC_BD_COUNT       8'h00
`define RBC_BD_NEXT        8'h04
`define RBC_BD_BUF         8'h08
`define RBC_BD_SIZE        8'h0C
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RBC_BIT_EL         31
`define RBC_BIT_SUSP       30
`define RBC_BIT_SF         19
`define RBC_BIT_C          15
`define RBC_BIT_B          14
`define RBC_BIT_OK         13
`define RBC_BIT_LEN        12
`define RBC_BIT_CRC        11
`define RBC_BIT_ALN        10
`define RBC_BIT_NORES      9
`define RBC_BIT_OVR        8
`define RBC_BIT_EOF        15
`define RBC_BIT_F          14
`define RBC_NULL_PTR       32'hFFFFFFFF
`define RBC_MAX_BUF        15'h4000
// Addressing modes
`define RBC_MODE_COMPAT    2'h0
`define RBC_MODE_SEG       2'h1
`define RBC_MODE_LINEAR    2'h2
// Register offsets
`define RBC_REG_CTRL       4'h0
`define RBC_REG_FDHEAD     4'h1
`define RBC_REG_STATE      4'h2
`define RBC_REG_NORES      4'h3
`define RBC_REG_FDCUR      4'h4
`define RBC_REG_BDCUR      4'h5
`define RBC_CTRL_START     0
`define RBC_CTRL_SAVEBAD   1
`define RBC_CTRL_MODE_LO   2
`endif

// ### core/rbc_sync.v
// Reset release synchroniser
`default_nettype none
module rbc_sync (
    input  wire ref_clk,
    input  wire rstn,
    output wire rst_sync_n
);
    reg s1;
    reg s2;
    // Two-stage release of the asynchronous reset
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
        end else begin
            s1 <= 1'b1;
            s2 <= s1;
        end
    end
    assign rst_sync_n = s2;
endmodule
`default_nettype wire

// ### verif/rbc_engine_checker.sv
// Concurrent checks on the engine's ports
`default_nettype none
module rbc_engine_checker (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        rx_ready,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0]  mem_be,
    input wire logic        mem_ack,
    input wire logic        ru_no_resources
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Request waiting for its answer, and the write flavour of it
    sequence s_wait;
        mem_req && !mem_ack;
    endsequence
    sequence s_wr_wait;
        s_wait ##0 mem_we;
    endsequence
    a_req_hold: assert property (
        s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    a_wr_hold: assert property (
        s_wr_wait |=> $stable(mem_wdata) && $stable(mem_be))
        else $error("write data changed before ack");
    a_wr_lanes: assert property (mem_req && mem_we |-> mem_be != 4'h0)
        else $error("memory write with no byte lane");
    a_addr_even: assert property (mem_req |-> !mem_addr[0])
        else $error("memory address odd");
    a_ready_nores: assert property (ru_no_resources |-> !rx_ready)
        else $error("bytes accepted without resources");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (
        $rose(rstn) |-> !mem_req && !rx_ready ##1 !mem_req)
        else $error("activity right after reset release");
endmodule
bind rbc_engine rbc_engine_checker u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_ready(rx_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .mem_ack(mem_ack), .ru_no_resources(ru_no_resources));
`default_nettype wire

// ### verif/rbc_mem_model.sv
// System memory holding host-prepared descriptors and buffers
`default_nettype none
module rbc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [3:0]  mem_be,
    output var  logic        mem_ack,
    output var  logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];
    logic [3:0]  wait_cnt = 4'h0;
    logic [31:0] key;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // Answer after lat idle cycles; read lane toggles every cycle except on a read ack
    always @(posedge ref_clk) begin
        key = {mem_addr[31:2], 2'h0};
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_cnt < lat) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                wait_cnt <= 4'h0;
                mem_ack <= 1'b1;
                if (!mem.exists(key)) mem[key] = 32'hFFFFFFFF;
                for (int i = 0; i < 4; i++)
                    if (mem_we && mem_be[i]) mem[key][8*i+:8] = mem_wdata[8*i+:8];
                if (!mem_we) mem_rdata <= mem[key];
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the receive buffer chaining engine
`default_nettype none
`include "rbc_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rstn, reg_wr, reg_rd, rx_valid, rx_last, rx_ready;
    logic        mem_req, mem_we, mem_ack, ru_ready, ru_no_resources;
    logic [3:0]  reg_addr, mem_be, lat;
    logic [7:0]  rx_data;
    logic [4:0]  rx_err;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd;
    int          fails, check_count, cycles;
    rbc_engine dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_err(rx_err), .rx_ready(rx_ready),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .ru_ready(ru_ready),
        .ru_no_resources(ru_no_resources));
    rbc_mem_model u_mem (.ref_clk(ref_clk), .lat(lat), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // -------------------------------------------------------------
    // Clock, hang limit and tasks
    // -------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // Host-built frame descriptor with preset data area
    task automatic fd(input logic [31:0] b, ctl, link, bd, size);
        u_mem.mem[b] = ctl;
        u_mem.mem[b+4] = link;
        u_mem.mem[b+8] = bd;
        u_mem.mem[b+12] = size << 16;
        u_mem.mem[b+32] = 32'hA5A5A5A5;
        u_mem.mem[b+36] = 32'hA5A5A5A5;
    endtask
    // Frame of n bytes counting up from base; stops if refused
    task automatic send(input logic [7:0] base, input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= base + i[7:0];
            rx_last <= (i == n - 1);
            t = 0;
            do begin
                @(negedge ref_clk);
                t++;
            end while (rx_ready !== 1'b1 && t < 300);
            @(posedge ref_clk);
            if (t >= 300) break;
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
    task automatic wait_done(input logic [31:0] a);
        for (int t = 0; t < 2000 && u_mem.mem[a][`RBC_BIT_C] !== 1'b1; t++)
            @(posedge ref_clk);
    endtask
    // -------------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------------
    initial begin
        {reg_wr, reg_rd, rx_valid, rx_last, rstn} = 5'h0;
        {reg_addr, reg_wdata, rx_data, rx_err, cycles} = 0;
        {fails, check_count, lat} = 0;
        do_reset();
        fd(32'h100, 0, 32'h200, `RBC_NULL_PTR, 8);
        fd(32'h200, 0, 32'h300, `RBC_NULL_PTR, 4);
        fd(32'h300, 32'h80000000, 0, `RBC_NULL_PTR, 8);
        reg_write(4'h0, 32'h1);
        repeat (20) @(posedge ref_clk);
        chk("compat start", 32'h0, {ru_ready, rx_ready, mem_req});
        reg_write(4'h1, 32'h100);
        reg_write(4'h0, 32'h9);
        send(8'h10, 6);
        wait_done(32'h100);
        chk("fd0 status", 32'hA000, u_mem.mem[32'h100] & 32'hE000);
        chk("fd0 data", 32'h13121110, u_mem.mem[32'h120]);
        chk("fd0 count", 32'h6, u_mem.mem[32'h10C] & 32'h3FFF);
        chk("fd0 bd ptr", `RBC_NULL_PTR, u_mem.mem[32'h108]);
        $display("test simplified done");
        send(8'h20, 9);
        for (int t = 0; t < 50 && rd !== 32'h1; t++) reg_read(4'h3, rd);
        chk("nores count", 32'h1, rd);
        chk("fd1 kept part", 32'h23222120, u_mem.mem[32'h220]);
        chk("fd1 beyond", 32'hA5A5A5A5, u_mem.mem[32'h224]);
        send(8'h40, 3);
        wait_done(32'h200);
        chk("fd1 reused", 32'h424140, u_mem.mem[32'h220] & 32'hFFFFFF);
        send(8'h50, 2);
        wait_done(32'h300);
        chk("fd2 next", 32'h5150, u_mem.mem[32'h320] & 32'hFFFF);
        $display("test truncation done");
        lat = 4'h3;
        do_reset();
        fd(32'h100, 32'h80000, 32'h200, 32'h400, 4);
        fd(32'h200, 32'h80080000, 0, `RBC_NULL_PTR, 4);
        for (int i = 0; i < 3; i++) begin
            u_mem.mem[32'h400+16*i] = 0;
            u_mem.mem[32'h404+16*i] = (i == 2) ? `RBC_NULL_PTR : 32'h410+16*i;
            u_mem.mem[32'h408+16*i] = 32'h800 + 256*i;
            u_mem.mem[32'h40C+16*i] = (i == 1) ? 8 : 6 - 2*i;
            u_mem.mem[32'h800+256*i] = 32'hA5A5A5A5;
            u_mem.mem[32'h804+256*i] = 32'hA5A5A5A5;
        end
        reg_write(4'h1, 32'h100);
        reg_write(4'h0, 32'h9);
        send(8'h10, 13);
        wait_done(32'h100);
        chk("fd data", 32'h13121110, u_mem.mem[32'h120]);
        chk("buf0 full", 32'h17161514, u_mem.mem[32'h800]);
        chk("buf0 limit", 32'hA5A51918, u_mem.mem[32'h804]);
        chk("bd0 count", 32'h6, u_mem.mem[32'h400] & 32'hBFFF);
        chk("bd1 last", 32'h8003, u_mem.mem[32'h410] & 32'hBFFF);
        chk("buf1 data", 32'h1C1B1A, u_mem.mem[32'h900] & 32'hFFFFFF);
        send(8'h60, 24);
        for (int t = 0; t < 500 && ru_no_resources !== 1'b1; t++)
            @(posedge ref_clk);
        chk("no resources", 32'h1, {31'h0, ru_no_resources});
        chk("fd1 bd ptr", 32'h420, u_mem.mem[32'h208]);
        $display("test flexible done");
        summarize();
    end
endmodule
`default_nettype wire
